/* hw/itdd_decoder.sv */
// isochronous transfer descriptor decoder and payload engine
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module itdd_decoder
  import itdd_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // register port
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [DATA_W-1:0] REG_RDATA,
  // token request towards the link
  output logic TOKEN_VALID,
  output itdd_tok_t TOKEN,
  input wire logic TOKEN_ACK,
  // outgoing payload
  output logic TX_VALID,
  output itdd_byte_t TX_BYTE,
  input wire logic TX_READY,
  // incoming payload, cannot be stalled
  input wire logic RX_VALID,
  input wire itdd_byte_t RX_BYTE,
  // engine status
  output logic BUSY
);

  typedef enum logic [2:0] {
    S_IDLE, S_TOKEN, S_TX_RD, S_TX_WAIT, S_RX, S_PKT_END, S_DONE, S_FAIL
  } itdd_state_t;

  itdd_state_t state_q;
  logic [31:0] dw0_q, dw1_q, dw2_q, dw3_q;
  logic [4:0] frame_q;
  logic [DATA_W-1:0] rdata_q;
  logic tok_valid_q;
  itdd_tok_t tok_q;
  logic tx_valid_q;
  itdd_byte_t tx_q;
  logic busy_q;
  logic [14:0] moved_q;
  logic [10:0] pkt_cnt_q;
  logic [1:0] pkt_idx_q;
  itdd_pid_t pid_q;

  // decoded descriptor fields
  logic [1:0] mult;
  logic [10:0] packet_size_limit;
  logic [14:0] total;
  logic [1:0] endpoint_category;
  logic [1:0] token_code;
  logic [15:0] payload_buffer_pointer;
  logic [4:0] start_frame;
  logic desc_valid;
  logic desc_ok;
  logic start;

  assign mult = dw0_q[DW0_MULT_HI:DW0_MULT_LO];
  assign packet_size_limit = dw0_q[DW0_SIZE_HI:DW0_SIZE_LO];
  assign total = dw0_q[DW0_TOTAL_HI:DW0_TOTAL_LO];
  assign desc_valid = dw0_q[DW0_VALID];
  assign endpoint_category = dw1_q[DW1_EPT_HI:DW1_EPT_LO];
  assign token_code = dw1_q[DW1_TOK_HI:DW1_TOK_LO];
  assign payload_buffer_pointer = dw2_q[DW2_PTR_HI:DW2_PTR_LO];
  // low three frame bits are don't care
  assign start_frame = dw2_q[DW2_FRM_HI:DW2_FRM_LO];

  // anything but an isochronous out or in with a nonzero multiplier is fatal
  assign desc_ok = (endpoint_category == EPT_ISO) && (mult != MULT_NONE) &&
                   (token_code == TOK_OUT || token_code == TOK_IN);
  assign start = (state_q == S_IDLE) && desc_valid &&
                 (frame_q == start_frame);

  // true while the current packet may still take a byte
  function automatic logic room_left(input logic [10:0] cnt,
                                     input logic [14:0] moved,
                                     input logic [10:0] limit,
                                     input logic [14:0] all);
    room_left = (cnt < limit) && (moved < all);
  endfunction

  // true when the byte about to move is the last one of its packet
  function automatic logic final_byte(input logic [10:0] cnt,
                                      input logic [14:0] moved,
                                      input logic [10:0] limit,
                                      input logic [14:0] all);
    final_byte = (cnt + ONE11 == limit) || (moved + ONE15 == all);
  endfunction

  // payload memory, addressed by the word pointer times eight
  logic [MEM_AW-1:0] eng_addr;
  logic [7:0] eng_rdata;
  logic eng_we;
  logic [31:0] bus_mem_rdata;
  logic bus_mem_hit;
  logic [15:0] bus_mem_off;

  assign eng_addr = MEM_AW'({payload_buffer_pointer, 3'h0} +
                            {1'b0, moved_q});
  assign eng_we = (state_q == S_RX) && RX_VALID &&
                  room_left(pkt_cnt_q, moved_q, packet_size_limit,
                            total);
  assign bus_mem_hit = (REG_ADDR >= MEM_BASE) && (REG_ADDR < MEM_END);
  assign bus_mem_off = REG_ADDR - MEM_BASE;

  itdd_payload_ram u_ram (
    .clk(CORE_CLK),
    .bus_we(REG_WR && bus_mem_hit),
    .bus_addr(bus_mem_off[MEM_AW-1:0]),
    .bus_wdata(REG_WDATA),
    .bus_rdata(bus_mem_rdata),
    .eng_we(eng_we),
    .eng_addr(eng_addr),
    .eng_wdata(RX_BYTE.data),
    .eng_rdata(eng_rdata)
  );

  // descriptor words; software writes are refused while the engine runs
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      dw0_q <= 32'h0;
      dw1_q <= 32'h0;
      dw2_q <= 32'h0;
    end
    else
    begin
      if (REG_WR && !busy_q && REG_ADDR == OFF_DW0)
        dw0_q <= REG_WDATA;
      if (REG_WR && !busy_q && REG_ADDR == OFF_DW1)
        dw1_q <= REG_WDATA;
      if (REG_WR && !busy_q && REG_ADDR == OFF_DW2)
        dw2_q <= REG_WDATA;
      if (state_q == S_DONE || state_q == S_FAIL)
        dw0_q[DW0_VALID] <= 1'b0;
    end
  end

  // completion word: active clears with valid, halt on fatal error
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      dw3_q <= 32'h0;
    else
    begin
      if (REG_WR && !busy_q && REG_ADDR == OFF_DW3)
        dw3_q <= REG_WDATA;
      if (state_q == S_PKT_END || state_q == S_DONE)
        dw3_q[DW3_DONE_HI:DW3_DONE_LO] <= moved_q;
      if (state_q == S_DONE || state_q == S_FAIL)
        dw3_q[DW3_ACTIVE] <= 1'b0;
      if (state_q == S_FAIL)
        dw3_q[DW3_HALT] <= 1'b1;
      // babble has no meaning here and is never raised
      if (start)
        dw3_q[DW3_BABBLE] <= 1'b0;
    end
  end

  // current frame number, written by software
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      frame_q <= 5'h0;
    else if (REG_WR && REG_ADDR == OFF_FRAME)
      frame_q <= REG_WDATA[4:0];
  end

  // read data stand one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      rdata_q <= 32'h0;
    else if (REG_RD)
    begin
      if (bus_mem_hit)
        rdata_q <= bus_mem_rdata;
      else
        unique case (REG_ADDR)
          OFF_DW0: rdata_q <= dw0_q;
          OFF_DW1: rdata_q <= dw1_q;
          OFF_DW2: rdata_q <= dw2_q;
          OFF_DW3: rdata_q <= dw3_q & ~(32'h1 << DW3_BABBLE);
          OFF_FRAME: rdata_q <= {27'h0, frame_q};
          OFF_STATUS: rdata_q <= {1'b0, moved_q, 8'h0, 2'h0, pkt_idx_q,
                                  pid_q, 1'b0, busy_q};
          default: rdata_q <= 32'h0;
        endcase
    end
    else
      rdata_q <= 32'h0;
  end

  // transfer state machine
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      state_q <= S_IDLE;
    else
      unique case (state_q)
        S_IDLE:
          if (start)
            state_q <= desc_ok ? S_TOKEN : S_FAIL;
        S_TOKEN:
          if (TOKEN_ACK)
            state_q <= tok_q.is_in ? S_RX : S_TX_RD;
        S_TX_RD:
          if (room_left(pkt_cnt_q, moved_q, packet_size_limit, total))
            state_q <= S_TX_WAIT;
          else
            state_q <= S_PKT_END;
        S_TX_WAIT:
          if (TX_READY)
            state_q <= tx_q.last ? S_PKT_END : S_TX_RD;
        S_RX:
          if (RX_VALID && RX_BYTE.last)
            state_q <= S_PKT_END;
        S_PKT_END:
          // a short packet or a spent budget ends the execution
          if (pkt_idx_q + ONE2 == mult || moved_q == total ||
              pkt_cnt_q < packet_size_limit)
            state_q <= S_DONE;
          else
            state_q <= S_TOKEN;
        S_DONE:
          state_q <= S_IDLE;
        S_FAIL:
          state_q <= S_IDLE;
      endcase
  end

  // byte and packet counters
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      moved_q <= 15'h0;
      pkt_cnt_q <= 11'h0;
      pkt_idx_q <= 2'h0;
    end
    else
    begin
      if (start)
      begin
        moved_q <= 15'h0;
        pkt_cnt_q <= 11'h0;
        pkt_idx_q <= 2'h0;
      end
      if (state_q == S_TOKEN)
        pkt_cnt_q <= 11'h0;
      if ((state_q == S_TX_WAIT && TX_READY) || eng_we)
      begin
        moved_q <= moved_q + ONE15;
        pkt_cnt_q <= pkt_cnt_q + ONE11;
      end
      if (state_q == S_PKT_END)
        pkt_idx_q <= pkt_idx_q + ONE2;
    end
  end

  // token request; the first pid follows the multiplier, then counts down
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      tok_valid_q <= 1'b0;
      tok_q <= '0;
      pid_q <= PID_DATA0;
    end
    else
    begin
      if (start && desc_ok)
      begin
        tok_valid_q <= 1'b1;
        pid_q <= itdd_pid_t'(mult - ONE2);
        tok_q.split <= dw1_q[DW1_SPLIT];
        tok_q.is_in <= (token_code == TOK_IN);
        tok_q.function_number <= dw1_q[DW1_FUNC_HI:DW1_FUNC_LO];
        tok_q.endpoint_number <= {dw1_q[DW1_EP_HI:DW1_EP_LO],
                                  dw0_q[DW0_EP0]};
        tok_q.pid <= itdd_pid_t'(mult - ONE2);
        tok_q.packet_size_limit <= packet_size_limit;
      end
      else if (state_q == S_TOKEN && TOKEN_ACK)
        tok_valid_q <= 1'b0;
      else if (state_q == S_PKT_END && pkt_idx_q + ONE2 != mult &&
               moved_q != total && pkt_cnt_q == packet_size_limit)
      begin
        tok_valid_q <= 1'b1;
        pid_q <= itdd_pid_t'(pid_q - ONE2);
        tok_q.pid <= itdd_pid_t'(pid_q - ONE2);
      end
    end
  end

  // outgoing byte, fetched from memory one at a time
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      tx_valid_q <= 1'b0;
      tx_q <= '0;
    end
    else if (state_q == S_TX_RD &&
             room_left(pkt_cnt_q, moved_q, packet_size_limit, total))
    begin
      tx_valid_q <= 1'b1;
      tx_q.data <= eng_rdata;
      tx_q.last <= final_byte(pkt_cnt_q, moved_q, packet_size_limit,
                              total);
    end
    else if (state_q == S_TX_WAIT && TX_READY)
      tx_valid_q <= 1'b0;
  end

  // busy covers every state but idle
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      busy_q <= 1'b0;
    else if (start)
      busy_q <= 1'b1;
    else if (state_q == S_DONE || state_q == S_FAIL)
      busy_q <= 1'b0;
  end

  assign REG_RDATA = rdata_q;
  assign TOKEN_VALID = tok_valid_q;
  assign TOKEN = tok_q;
  assign TX_VALID = tx_valid_q;
  assign TX_BYTE = tx_q;
  assign BUSY = busy_q;

endmodule

/* hw/itdd_payload_ram.sv */
// payload byte memory with a word port for software and a byte port
`timescale 1ns/10ps
module itdd_payload_ram
  import itdd_pkg::*;
(
  // clock
  input wire logic clk,
  // software side, word aligned, little endian
  input wire logic bus_we,
  input wire logic [MEM_AW-1:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  // engine side
  input wire logic eng_we,
  input wire logic [MEM_AW-1:0] eng_addr,
  input wire logic [7:0] eng_wdata,
  output logic [7:0] eng_rdata
);

  logic [7:0] mem [MEM_BYTES];
  logic [MEM_AW-1:0] base;

  assign base = {bus_addr[MEM_AW-1:2], 2'h0};

  // the engine write comes last so it wins a collision on the same byte
  always_ff @(posedge clk)
  begin
    if (bus_we)
    begin
      for (int i = 0; i < 4; i++)
        mem[base + MEM_AW'(i)] <= bus_wdata[8*i +: 8];
    end
    if (eng_we)
      mem[eng_addr] <= eng_wdata;
  end

  assign bus_rdata = {mem[base + MEM_AW'(3)], mem[base + MEM_AW'(2)],
                      mem[base + MEM_AW'(1)], mem[base]};
  assign eng_rdata = mem[eng_addr];

endmodule

/* hw/itdd_pkg.sv */
// constants and types for the isochronous descriptor decoder
package itdd_pkg;

  // register port
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam logic [15:0] OFF_DW0 = 16'h0000;
  localparam logic [15:0] OFF_DW1 = 16'h0004;
  localparam logic [15:0] OFF_DW2 = 16'h0008;
  localparam logic [15:0] OFF_DW3 = 16'h000c;
  localparam logic [15:0] OFF_FRAME = 16'h0010;
  localparam logic [15:0] OFF_STATUS = 16'h0014;
  localparam logic [15:0] MEM_BASE = 16'h0400;
  localparam logic [15:0] MEM_END = 16'h0c00;

  // payload memory
  localparam int MEM_BYTES = 2048;
  localparam int MEM_AW = 11;
  localparam int PTR_SHIFT = 3;

  // descriptor word 0
  localparam int DW0_EP0 = 31;
  localparam int DW0_MULT_HI = 30;
  localparam int DW0_MULT_LO = 29;
  localparam int DW0_SIZE_HI = 28;
  localparam int DW0_SIZE_LO = 18;
  localparam int DW0_TOTAL_HI = 17;
  localparam int DW0_TOTAL_LO = 3;
  localparam int DW0_VALID = 0;
  // descriptor word 1
  localparam int DW1_SPLIT = 14;
  localparam int DW1_EPT_HI = 13;
  localparam int DW1_EPT_LO = 12;
  localparam int DW1_TOK_HI = 11;
  localparam int DW1_TOK_LO = 10;
  localparam int DW1_FUNC_HI = 9;
  localparam int DW1_FUNC_LO = 3;
  localparam int DW1_EP_HI = 2;
  localparam int DW1_EP_LO = 0;
  // descriptor word 2
  localparam int DW2_PTR_HI = 23;
  localparam int DW2_PTR_LO = 8;
  localparam int DW2_FRM_HI = 7;
  localparam int DW2_FRM_LO = 3;
  // descriptor word 3
  localparam int DW3_ACTIVE = 31;
  localparam int DW3_HALT = 30;
  localparam int DW3_BABBLE = 29;
  localparam int DW3_DONE_HI = 14;
  localparam int DW3_DONE_LO = 0;

  // status register
  localparam int ST_BUSY = 0;
  localparam int ST_PID_LO = 2;
  localparam int ST_PKT_LO = 4;
  localparam int ST_MOVED_LO = 16;

  // encodings
  localparam logic [1:0] EPT_ISO = 2'h1;
  localparam logic [1:0] TOK_OUT = 2'h0;
  localparam logic [1:0] TOK_IN = 2'h1;
  localparam logic [1:0] MULT_NONE = 2'h0;
  localparam logic [1:0] ONE2 = 2'h1;
  localparam logic [14:0] ONE15 = 15'h0001;
  localparam logic [10:0] ONE11 = 11'h001;

  typedef enum logic [1:0] {PID_DATA0, PID_DATA1, PID_DATA2, PID_RSVD}
    itdd_pid_t;

  typedef struct packed {
    logic split;
    logic is_in;
    logic [6:0] function_number;
    logic [3:0] endpoint_number;
    itdd_pid_t pid;
    logic [10:0] packet_size_limit;
  } itdd_tok_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } itdd_byte_t;

endpackage

/* test/iso_transfer_descriptor_decoder_test.sv */
// self-checking bench for the isochronous descriptor decoder
`timescale 1ns/10ps
module iso_transfer_descriptor_decoder_test;
  import itdd_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic slow = 1'b0;
  logic [7:0] rx_len = '0;
  logic [31:0] reg_rdata;
  logic tok_valid, tok_ack, tx_valid, tx_ready, rx_valid, busy;
  itdd_tok_t tok;
  itdd_byte_t tx_byte, rx_byte;
  integer seed = 32'h6ef3d59c;
  int checked = 0;
  int fail_count = 0;
  itdd_tok_t tok_q[$];
  itdd_byte_t tx_q[$];
  logic [7:0] mb[16];

  always #2.5 core_clk = ~core_clk;

  itdd_decoder i_dut (.CORE_CLK(core_clk), .RST(rst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .TOKEN_VALID(tok_valid), .TOKEN(tok),
    .TOKEN_ACK(tok_ack), .TX_VALID(tx_valid), .TX_BYTE(tx_byte),
    .TX_READY(tx_ready), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
    .BUSY(busy));
  itdd_endpoint_model i_ep (.clk(core_clk), .rst(rst), .slow(slow),
    .rx_len(rx_len), .token_valid(tok_valid), .token(tok),
    .token_ack(tok_ack), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte));

  always @(posedge core_clk)
  begin
    if (tok_valid && tok_ack)
      tok_q.push_back(tok);
    if (tx_valid && tx_ready)
      tx_q.push_back(tx_byte);
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // a gap cycle follows each write so strobes never collide
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    // take the data while they stand, clear of the edge that launched them
    #1;
    d = reg_rdata;
    @(posedge core_clk);
  endtask

  task automatic wrap_up;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic run(input logic tin, split, input logic [1:0] mult,
                     input int size, total, rxn);
    logic [31:0] w;
    logic [6:0] fn;
    logic [3:0] ep;
    logic [7:0] frm;
    int ptr, moved, n, k;
    fn = 7'($random(seed));
    ep = 4'($random(seed));
    frm = 8'($random(seed));
    ptr = {$random(seed)} % 250;
    for (int j = 0; j < 4; j++)
    begin
      w = $random(seed);
      {mb[4*j+3], mb[4*j+2], mb[4*j+1], mb[4*j]} = w;
      wr(MEM_BASE + 16'(ptr * 8 + 4 * j), w);
    end
    tok_q.delete();
    tx_q.delete();
    rx_len <= 8'(rxn);
    wr(OFF_DW1, {17'h0, split, EPT_ISO, 1'b0, tin, fn, ep[3:1]});
    wr(OFF_DW2, {8'h00, 16'(ptr), frm});
    wr(OFF_DW3, '0);
    wr(OFF_FRAME, 32'(frm[7:3] + 5'h1));
    wr(OFF_DW0, {ep[0], mult, 11'(size), 15'(total), 3'h1});
    repeat (4) @(posedge core_clk);
    chk("early start", 32'(tok_q.size()) + 32'(busy), 0);
    wr(OFF_FRAME, 32'(frm[7:3]));
    repeat (3) @(posedge core_clk);
    for (k = 0; k < 2000 && busy !== 1'b0; k++)
      @(posedge core_clk);
    moved = 0;
    k = 0;
    while (k < mult && moved < total)
    begin
      n = (total - moved < size) ? total - moved : size;
      if (tin && rxn < n)
        n = rxn;
      chk("token", {tok_q[k].split, tok_q[k].is_in, tok_q[k].function_number,
          tok_q[k].endpoint_number, tok_q[k].packet_size_limit},
          {split, tin, fn, ep, 11'(size)});
      chk("pid", tok_q[k].pid, 2'(mult - 1 - k));
      for (int i = 0; i < n && !tin; i++)
        chk("tx byte", tx_q[moved + i], {mb[moved + i], i == n - 1});
      moved += n;
      k++;
      if (n < size)
        break;
    end
    chk("tokens", tok_q.size(), k);
    chk("tx count", tx_q.size(), tin ? 0 : moved);
    rd(OFF_DW3, w);
    chk("done count", w[DW3_DONE_HI:DW3_DONE_LO], moved);
    chk("babble", w[DW3_BABBLE], 0);
    rd(OFF_DW0, w);
    chk("valid", w[DW0_VALID], 0);
    for (int j = 0; j < 8 && tin; j++)
    begin
      if (j % 4 == 0)
        rd(MEM_BASE + 16'(ptr * 8 + j), w);
      chk("rx byte", w[8*(j%4) +: 8], j < moved ? 8'ha0 + j : mb[j]);
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    wrap_up();
  end

  initial
  begin
    logic [31:0] w;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    wr(16'h0020, '1);
    for (int a = 0; a <= 32'h20; a += 4)
    begin
      rd(16'(a), w);
      chk("reset value", w, 0);
    end
    run(1'b0, 1'b1, 2'h3, 2, 5, 0);
    slow <= 1'b1;
    run(1'b0, 1'b0, 2'h2, 4, 4, 0);
    run(1'b1, 1'b0, 2'h1, 4, 8, 3);
    slow <= 1'b0;
    run(1'b1, 1'b1, 2'h1, 2, 8, 4);
    // endpoint type 10 is refused as a fatal descriptor
    tok_q.delete();
    wr(OFF_DW1, {18'h0, 2'h2, 12'h0});
    wr(OFF_DW0, 32'h2000_0009);
    repeat (10) @(posedge core_clk);
    rd(OFF_DW0, w);
    chk("fatal valid", w[DW0_VALID], 0);
    rd(OFF_DW3, w);
    chk("fatal halt", w[DW3_HALT], 1);
    chk("fatal tokens", tok_q.size(), 0);
    wrap_up();
  end
endmodule

/* test/itdd_decoder_asserts.sv */
// port assertions for the isochronous descriptor decoder
`timescale 1ns/10ps
module itdd_decoder_asserts
  import itdd_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // register port
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA,
  // link side and engine status
  input wire logic TOKEN_VALID,
  input wire itdd_tok_t TOKEN,
  input wire logic TOKEN_ACK,
  input wire logic TX_VALID,
  input wire itdd_byte_t TX_BYTE,
  input wire logic TX_READY,
  input wire logic BUSY
);
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  tok_hold_a: assert property (
    TOKEN_VALID && !TOKEN_ACK |=> TOKEN_VALID && $stable(TOKEN))
    else $error("token changed before ack");
  tok_release_a: assert property (
    TOKEN_VALID && TOKEN_ACK |=> !TOKEN_VALID)
    else $error("token held after ack");
  tx_hold_a: assert property (
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_BYTE))
    else $error("byte changed before ready");
  pid_code_a: assert property (
    TOKEN_VALID |-> TOKEN.pid != PID_RSVD)
    else $error("reserved pid offered");
  token_order_a: assert property (
    TOKEN_VALID |-> !TX_VALID)
    else $error("payload offered beside token");
  rd_idle_a: assert property (
    !$past(REG_RD) |-> REG_RDATA == '0)
    else $error("read data outside read slot");
  babble_hidden_a: assert property (
    $past(REG_RD) && $past(REG_ADDR) == OFF_DW3 |-> !REG_RDATA[DW3_BABBLE])
    else $error("babble reported");
  link_busy_a: assert property (
    TOKEN_VALID || TX_VALID |-> BUSY)
    else $error("link traffic while idle");
endmodule

bind itdd_decoder itdd_decoder_asserts i_chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .TOKEN_VALID(TOKEN_VALID), .TOKEN(TOKEN),
  .TOKEN_ACK(TOKEN_ACK), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE),
  .TX_READY(TX_READY), .BUSY(BUSY));

/* test/itdd_endpoint_model.sv */
// behavioural usb function endpoint on the decoder link side
`timescale 1ns/10ps
module itdd_endpoint_model
  import itdd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench control
  input wire logic slow,
  input wire logic [7:0] rx_len,
  // link side
  input wire logic token_valid,
  input wire itdd_tok_t token,
  output logic token_ack,
  input wire logic tx_valid,
  input wire itdd_byte_t tx_byte,
  output logic tx_ready,
  output logic rx_valid,
  output itdd_byte_t rx_byte
);
  integer seed = 32'h13579bdf;
  initial
  begin
    token_ack = 1'b0;
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_byte = '0;
  end
  // a slow endpoint stalls at random so held bytes get exercised
  always @(posedge clk)
    tx_ready <= !slow || $random(seed) % 4 == 0;
  always
  begin
    @(posedge clk);
    if (token_valid === 1'b1 && !rst)
    begin
      repeat (slow ? 3 : 0)
        @(posedge clk);
      token_ack <= 1'b1;
      @(posedge clk);
      token_ack <= 1'b0;
      if (token.is_in)
      begin
        // one idle cycle so no byte lands before the receive state
        @(posedge clk);
        for (int i = 0; i < rx_len; i++)
        begin
          rx_valid <= 1'b1;
          rx_byte <= {8'(8'ha0 + i), i == rx_len - 1};
          @(posedge clk);
        end
        rx_valid <= 1'b0;
        // released bus shows the inverse, never a stale byte
        rx_byte <= ~rx_byte;
      end
    end
  end
endmodule
